// *** rtl/hbs_sequencer.sv ***
// Purpose: Mode sequencer, protection and bridge switch control of an H-bridge driver.
// Assumes: Pins and analog comparator flags are asynchronous; registers sit on classic Wishbone.
// Notes: Every reaction to a pin or sense flag lags it by the three-stage synchroniser.
`timescale 1ns/1ns
module hbs_sequencer #(
	parameter int TURN_ON_CYC = hbs_pkg::TURN_ON_CYC,
	parameter int CHOP_PERIOD = hbs_pkg::CHOP_PERIOD_CYC
) (
	// Clock and reset.
	input wire logic clk_i,
	input wire logic rst_i,
	// Wishbone slave.
	input wire logic [7:0] wb_adr_i,
	input wire logic [31:0] wb_dat_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic wb_we_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	// Control pins from the microcontroller.
	input wire logic dir_input_a_i,
	input wire logic dir_input_b_i,
	input wire logic wake_enable_pin_i,
	input wire logic output_disable_pin_i,
	// Analog comparator and supply flags.
	input wire hbs_pkg::hbs_sense_t sense_i,
	// Bridge drive.
	output hbs_pkg::hbs_gates_t gates_o,
	output logic bridge_out_a_oe_o,
	output logic bridge_out_b_oe_o,
	output logic [2:0] slew_rate_o,
	output logic regulator_en_o,
	// Open-drain fault status pin.
	output logic fault_status_n_o,
	output logic fault_status_n_oe_o
);

	////////////////////////////////////////////////////////////////////////////////
	// Input synchroniser: a change counts once the second and third stages agree.
	logic [11:0] sync1;
	logic [11:0] sync2;
	logic [11:0] sync3;
	logic [11:0] filt;
	wire [11:0] raw_in = {dir_input_a_i, dir_input_b_i, wake_enable_pin_i, output_disable_pin_i, sense_i};
	wire [11:0] agree = ~(sync2 ^ sync3);
	wire [11:0] next_filt = (sync3 & agree) | (filt & ~agree);

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			sync1 <= 12'h000;
			sync2 <= 12'h000;
			sync3 <= 12'h000;
			filt <= 12'h000;
		end else begin
			sync1 <= raw_in;
			sync2 <= sync1;
			sync3 <= sync2;
			filt <= next_filt;
		end
	end

	hbs_pkg::hbs_sense_t sense;
	assign sense = filt[7:0];
	wire pin_dir_a = filt[11];
	wire pin_dir_b = filt[10];
	wire en_lvl = filt[9];
	wire dis_lvl = filt[8];

	logic en_prev;
	logic dis_prev;
	wire en_rise = en_lvl & ~en_prev;
	wire dis_fall = ~dis_lvl & dis_prev;

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			en_prev <= 1'b0;
			dis_prev <= 1'b0;
		end else begin
			en_prev <= en_lvl;
			dis_prev <= dis_lvl;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Register slave: one-cycle answer, unmapped addresses read zero and ignore writes.
	logic [7:0] ctrl;
	logic [4:0] latched;
	hbs_pkg::hbs_mode_t mode;
	hbs_pkg::hbs_mode_t next_mode;

	wire wb_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
	wire hit_ctrl = wb_adr_i == hbs_pkg::REG_CTRL;
	wire hit_status = wb_adr_i == hbs_pkg::REG_STATUS;
	wire wr_ctrl = wb_req & wb_we_i & hit_ctrl & wb_sel_i[0];
	wire wr_status = wb_req & wb_we_i & hit_status & wb_sel_i[0];
	wire [31:0] status_word = {21'h000000, mode, 3'h0, latched};
	wire [31:0] next_rdata = hit_ctrl ? {24'h000000, 1'b0, ctrl[6:0]} : (hit_status ? status_word : 32'h00000000);

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= 32'h00000000;
			ctrl <= hbs_pkg::CTRL_RESET;
		end else begin
			wb_ack_o <= wb_req;
			wb_dat_o <= wb_req ? next_rdata : 32'h00000000;
			if (wr_ctrl) begin
				ctrl <= {1'b0, wb_dat_i[6:0]};
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Fault latches: a new event wins over a clear in the same cycle.
	wire powered = (mode != hbs_pkg::HBS_SLEEP) & (mode != hbs_pkg::HBS_POWERDOWN);
	logic [hbs_pkg::TIMER_W-1:0] tmr;
	wire turn_on_late = tmr >= hbs_pkg::TIMER_W'(TURN_ON_CYC - 1);
	wire to_evt = (mode == hbs_pkg::HBS_POWERUP) & en_lvl & ~sense.supplies_ready & turn_on_late;
	wire [4:0] present = {
		to_evt,
		sense.thermal_warn,
		powered & ~sense.pump_ok & (mode != hbs_pkg::HBS_POWERUP),
		sense.overtemp,
		sense.overcurrent
	};
	wire clr_edge = dis_fall | en_rise;
	wire [4:0] clr_mask = (wr_status ? wb_dat_i[4:0] : 5'h00) | (clr_edge ? 5'h1f : 5'h00);
	wire [4:0] next_latched = (latched & ~clr_mask) | present;
	wire fault_now = |(present & hbs_pkg::HARD_FAULTS);
	wire hard = fault_now | (|(latched & hbs_pkg::HARD_FAULTS));

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			latched <= hbs_pkg::FAULT_RESET;
		end else begin
			latched <= next_latched;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Mode machine and its timers.
	logic [hbs_pkg::PULSE_W-1:0] pulse_cnt;
	wire pulse_done = pulse_cnt >= hbs_pkg::PULSE_W'(hbs_pkg::FAULT_PULSE_CYC);
	wire pd_done = tmr >= hbs_pkg::TIMER_W'(hbs_pkg::POWERDOWN_DELAY_CYC - 1);
	wire op_normal = ctrl[hbs_pkg::CTRL_OUT_EN] & ~dis_lvl;
	hbs_pkg::hbs_mode_t op_mode;
	assign op_mode = op_normal ? hbs_pkg::HBS_NORMAL : hbs_pkg::HBS_STANDBY;

	always_comb begin
		next_mode = mode;
		case (mode)
			hbs_pkg::HBS_SLEEP: begin
				if (en_rise & sense.rail_ok) begin
					next_mode = hbs_pkg::HBS_POWERUP;
				end
			end
			hbs_pkg::HBS_POWERUP: begin
				if (~en_lvl) begin
					next_mode = hbs_pkg::HBS_POWERDOWN;
				end else if (pulse_done & sense.pump_ok & ~hard) begin
					next_mode = op_mode;
				end else if (to_evt) begin
					next_mode = hbs_pkg::HBS_FAULT;
				end
			end
			hbs_pkg::HBS_STANDBY, hbs_pkg::HBS_NORMAL: begin
				if (~en_lvl) begin
					next_mode = hbs_pkg::HBS_POWERDOWN;
				end else if (hard) begin
					next_mode = hbs_pkg::HBS_FAULT;
				end else begin
					next_mode = op_mode;
				end
			end
			hbs_pkg::HBS_FAULT: begin
				if (~en_lvl) begin
					next_mode = hbs_pkg::HBS_POWERDOWN;
				end else if (~hard) begin
					next_mode = op_mode;
				end
			end
			hbs_pkg::HBS_POWERDOWN: begin
				if (pd_done & ~sense.supplies_ready & ~dis_lvl) begin
					next_mode = hbs_pkg::HBS_SLEEP;
				end
			end
			default: begin
				next_mode = hbs_pkg::HBS_SLEEP;
			end
		endcase
	end

	// The timer saturates so that a stuck supply never wraps into a false deadline.
	wire tmr_max = &tmr;
	wire [hbs_pkg::TIMER_W-1:0] next_tmr = (next_mode != mode) ? '0 : (tmr_max ? tmr : tmr + 1'b1);
	wire pulse_run = (mode == hbs_pkg::HBS_POWERUP) & fault_status_n_oe_o & ~pulse_done;
	wire [hbs_pkg::PULSE_W-1:0] next_pulse = (mode != hbs_pkg::HBS_POWERUP) ? '0 : (pulse_run ? pulse_cnt + 1'b1 : pulse_cnt);

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			mode <= hbs_pkg::HBS_SLEEP;
			tmr <= '0;
			pulse_cnt <= '0;
		end else begin
			mode <= next_mode;
			tmr <= next_tmr;
			pulse_cnt <= next_pulse;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Current-limit chopping: a limit hit blanks the high side until the period ends.
	// Doubling the period under thermal stress halves switching loss; the peak stays at the limit.
	logic [15:0] chop_cnt;
	logic chop_off;
	wire [15:0] chop_period = sense.thermal_stress ? 16'(2 * CHOP_PERIOD) : 16'(CHOP_PERIOD);
	wire chop_wrap = chop_cnt >= chop_period - 16'h0001;
	wire [15:0] next_chop_cnt = chop_wrap ? 16'h0000 : chop_cnt + 16'h0001;
	wire next_chop_off = sense.current_limit | (chop_off & ~chop_wrap);

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			chop_cnt <= 16'h0000;
			chop_off <= 1'b0;
		end else begin
			chop_cnt <= next_chop_cnt;
			chop_off <= next_chop_off;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Bridge switch pattern; half-bridge mode uses only the A half and floats the B half.
	wire dir_a = pin_dir_a | ctrl[hbs_pkg::CTRL_DIR_A];
	wire dir_b = pin_dir_b | ctrl[hbs_pkg::CTRL_DIR_B];
	wire half = ctrl[hbs_pkg::CTRL_HALF];
	wire drive = (next_mode == hbs_pkg::HBS_NORMAL) & ~fault_now;
	wire blank = chop_off | sense.current_limit;
	hbs_pkg::hbs_gates_t next_gates;
	assign next_gates.hs_a = drive & dir_a & ~blank;
	assign next_gates.ls_a = drive & ~dir_a;
	assign next_gates.hs_b = drive & ~half & dir_b & ~blank;
	assign next_gates.ls_b = drive & ~half & ~dir_b;
	wire next_oe_a = drive;
	wire next_oe_b = drive & ~half;
	wire next_reg_en = (next_mode != hbs_pkg::HBS_SLEEP) & ((next_mode != hbs_pkg::HBS_POWERDOWN) | ~pd_done);
	wire next_fs_oe = ((next_mode == hbs_pkg::HBS_POWERUP) & sense.supplies_ready)
		| (next_mode == hbs_pkg::HBS_FAULT)
		| (next_mode == hbs_pkg::HBS_POWERDOWN);

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			gates_o <= '0;
			bridge_out_a_oe_o <= 1'b0;
			bridge_out_b_oe_o <= 1'b0;
			slew_rate_o <= 3'h3;
			regulator_en_o <= 1'b0;
			fault_status_n_o <= 1'b0;
			fault_status_n_oe_o <= 1'b0;
		end else begin
			gates_o <= next_gates;
			bridge_out_a_oe_o <= next_oe_a;
			bridge_out_b_oe_o <= next_oe_b;
			slew_rate_o <= ctrl[hbs_pkg::CTRL_SLEW_LSB +: 3];
			regulator_en_o <= next_reg_en;
			fault_status_n_o <= 1'b0;
			fault_status_n_oe_o <= next_fs_oe;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Checks.
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);

	a_sleep_all_off: assert property (mode == hbs_pkg::HBS_SLEEP |-> gates_o == '0 && !regulator_en_o
		&& !bridge_out_a_oe_o && !fault_status_n_oe_o) else $error("sleep mode left something active");
	a_standby_hiz: assert property (mode == hbs_pkg::HBS_STANDBY |-> !bridge_out_a_oe_o && !bridge_out_b_oe_o
		&& regulator_en_o) else $error("standby outputs not high impedance");
	a_overcurrent_off: assert property (sense.overcurrent |=> gates_o == '0 ##1 mode != hbs_pkg::HBS_NORMAL)
		else $error("overcurrent did not shut outputs");
	a_overtemp_fault: assert property (mode == hbs_pkg::HBS_NORMAL && en_lvl && sense.overtemp
		|=> mode == hbs_pkg::HBS_FAULT && !bridge_out_a_oe_o) else $error("overtemp did not disable outputs");
	a_normal_fault_move: assert property (mode == hbs_pkg::HBS_NORMAL && en_lvl && hard
		|=> mode == hbs_pkg::HBS_FAULT) else $error("fault not entered from normal");
	a_fault_pin_low: assert property (mode == hbs_pkg::HBS_FAULT |-> fault_status_n_oe_o && !fault_status_n_o
		&& gates_o == '0) else $error("fault mode without pin low");
	a_limit_chop: assert property (sense.current_limit |=> !gates_o.hs_a && !gates_o.hs_b)
		else $error("high side not chopped at limit");
	a_wake_rail: assert property ($rose(mode == hbs_pkg::HBS_POWERUP) |-> $past(sense.rail_ok) && $past(en_rise))
		else $error("power-up without valid wake");
	a_pulse_min: assert property (mode == hbs_pkg::HBS_POWERUP && next_mode inside {hbs_pkg::HBS_STANDBY,
		hbs_pkg::HBS_NORMAL} |-> pulse_cnt >= 8'd20 && sense.pump_ok) else $error("power-up fault pulse too short");
	a_enable_fall: assert property ($fell(en_lvl) && powered |=> mode == hbs_pkg::HBS_POWERDOWN
		##1 (gates_o == '0 && !bridge_out_a_oe_o && fault_status_n_oe_o)) else $error("enable fall not handled");
	a_pd_delay_hold: assert property ($rose(mode == hbs_pkg::HBS_POWERDOWN) |-> (fault_status_n_oe_o
		&& regulator_en_o)[*8]) else $error("power-down began too early");
	a_pd_needs_dis: assert property (mode == hbs_pkg::HBS_POWERDOWN && dis_lvl |=> mode == hbs_pkg::HBS_POWERDOWN)
		else $error("fault pin released with disable high");
	a_pd_supplies: assert property (mode == hbs_pkg::HBS_POWERDOWN && sense.supplies_ready |=> fault_status_n_oe_o)
		else $error("fault pin released before supplies off");
	a_clear_event: assert property ($fell(latched[hbs_pkg::ST_OVERTEMP]) |-> $past(clr_mask[1])
		&& !$past(sense.overtemp)) else $error("fault cleared without event");
	a_fault_exit: assert property (mode == hbs_pkg::HBS_FAULT && en_lvl && hard |=> mode == hbs_pkg::HBS_FAULT)
		else $error("fault left while still latched");

	c_reach_normal: cover property (mode == hbs_pkg::HBS_POWERUP ##[1:300] mode == hbs_pkg::HBS_NORMAL);
	c_fault_recover: cover property (mode == hbs_pkg::HBS_FAULT ##[1:300] mode == hbs_pkg::HBS_NORMAL);
	c_sleep_again: cover property (mode == hbs_pkg::HBS_POWERDOWN ##[1:1000] mode == hbs_pkg::HBS_SLEEP);
	c_chop_active: cover property (mode == hbs_pkg::HBS_NORMAL && sense.current_limit && sense.thermal_stress);

endmodule : hbs_sequencer

// *** rtl/hbs_pkg.sv ***
// Purpose: Shared constants and types of the H-bridge mode sequencer.
// Assumes: A 20 MHz system clock; the fault-pulse, power-down and turn-on counts below are derived from it.
// Notes: Fault-pulse, power-down and turn-on figures are kept in nanoseconds and converted to cycles here; the chop period is given in cycles.
package hbs_pkg;

	////////////////////////////////////////////////////////////////////////////////
	localparam int CLK_MHZ = 20;
	localparam int FAULT_PULSE_MIN_NS = 1000;
	localparam int FAULT_PULSE_CYC = (FAULT_PULSE_MIN_NS * CLK_MHZ + 999) / 1000;
	localparam int POWERDOWN_DELAY_MIN_NS = 8000;
	localparam int POWERDOWN_DELAY_CYC = (POWERDOWN_DELAY_MIN_NS * CLK_MHZ + 999) / 1000;
	localparam int TURN_ON_MAX_NS = 1000000;
	localparam int TURN_ON_CYC = TURN_ON_MAX_NS * CLK_MHZ / 1000;
	localparam int CHOP_PERIOD_CYC = 1000;
	localparam int TIMER_W = 16;
	localparam int PULSE_W = 8;

	////////////////////////////////////////////////////////////////////////////////
	localparam logic [7:0] REG_CTRL = 8'h00;
	localparam logic [7:0] REG_STATUS = 8'h04;
	localparam int CTRL_DIR_A = 0;
	localparam int CTRL_DIR_B = 1;
	localparam int CTRL_OUT_EN = 2;
	localparam int CTRL_HALF = 3;
	localparam int CTRL_SLEW_LSB = 4;
	localparam logic [7:0] CTRL_RESET = 8'h30;
	localparam int ST_OVERCURRENT = 0;
	localparam int ST_OVERTEMP = 1;
	localparam int ST_PUMP_UV = 2;
	localparam int ST_THERMAL_WARN = 3;
	localparam int ST_TURN_ON_TIMEOUT = 4;
	localparam int FAULT_W = 5;
	localparam logic [4:0] FAULT_RESET = 5'h00;
	localparam logic [4:0] HARD_FAULTS = 5'h17;

	////////////////////////////////////////////////////////////////////////////////
	typedef enum logic [2:0] {
		HBS_SLEEP = 3'h0,
		HBS_POWERUP = 3'h1,
		HBS_STANDBY = 3'h3,
		HBS_NORMAL = 3'h2,
		HBS_FAULT = 3'h6,
		HBS_POWERDOWN = 3'h4
	} hbs_mode_t;

	typedef struct packed {
		logic hs_a;
		logic ls_a;
		logic hs_b;
		logic ls_b;
	} hbs_gates_t;

	typedef struct packed {
		logic overcurrent;
		logic current_limit;
		logic overtemp;
		logic thermal_warn;
		logic thermal_stress;
		logic rail_ok;
		logic supplies_ready;
		logic pump_ok;
	} hbs_sense_t;

endpackage : hbs_pkg

// *** dv/hbs_supply_model.sv ***
// Purpose: Behavioural model of the internal supplies and charge pump seen by the sequencer.
// Assumes: Supplies settle a fixed number of cycles after the regulator enable rises.
// Notes: Dropping the enable collapses the supplies at once, so the power-down tail is short.
`timescale 1ns/1ns
module hbs_supply_model #(
	parameter int DELAY = 30
) (
	// Clock.
	input wire logic clk_i,
	// Regulator control.
	input wire logic regulator_en_i,
	// Supply flags.
	output logic supplies_ready_o,
	output logic pump_ok_o
);
	int cnt = 0;

	always_ff @(posedge clk_i) begin
		if (!regulator_en_i) begin
			cnt <= 0;
		end else if (cnt < DELAY) begin
			cnt <= cnt + 1;
		end
	end
	assign supplies_ready_o = regulator_en_i && (cnt >= DELAY);
	assign pump_ok_o = supplies_ready_o;
endmodule : hbs_supply_model

// *** dv/tb_hbs_sequencer.sv ***
// Purpose: Self-checking bench of the H-bridge mode sequencer.
// Assumes: Pins reach the logic about five cycles late, so pin steps are followed by a settle wait.
// Notes: Reduced turn-on and chop counts keep the run short.
`timescale 1ns/1ns
module tb_hbs_sequencer;
	logic clk_i = 0, rst_i = 1, wb_we_i = 0, wb_cyc_i = 0, wb_stb_i = 0, wb_ack_o;
	logic [7:0] wb_adr_i = 0;
	logic [31:0] wb_dat_i = 0, wb_dat_o, rd;
	logic [3:0] wb_sel_i = 0;
	localparam int CHOP = 20;
	logic dir_a = 0, dir_b = 0, en = 0, dis = 0, oc = 0, rail = 0, sup, pump;
	logic lim = 0, ot = 0, tw = 0, ts = 0;
	logic oe_a, oe_b, reg_en, fs_n, fs_oe;
	logic [2:0] slew;
	hbs_pkg::hbs_gates_t gates;
	int err_total = 0, checks_done = 0, cycles = 0, n, g;
	logic a, b, h;

	////////////////////////////////////////////////////////////////////////////////
	always #25 clk_i = ~clk_i;
	hbs_sequencer #(.TURN_ON_CYC(200), .CHOP_PERIOD(CHOP)) hbs_sequencer_i (.clk_i(clk_i), .rst_i(rst_i),
		.wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i), .wb_sel_i(wb_sel_i), .wb_we_i(wb_we_i), .wb_cyc_i(wb_cyc_i),
		.wb_stb_i(wb_stb_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .dir_input_a_i(dir_a),
		.dir_input_b_i(dir_b), .wake_enable_pin_i(en), .output_disable_pin_i(dis),
		.sense_i({oc, lim, ot, tw, ts, rail, sup, pump}), .gates_o(gates), .bridge_out_a_oe_o(oe_a),
		.bridge_out_b_oe_o(oe_b), .slew_rate_o(slew), .regulator_en_o(reg_en), .fault_status_n_o(fs_n),
		.fault_status_n_oe_o(fs_oe));
	hbs_supply_model #(.DELAY(30)) hbs_supply_model_i (.clk_i(clk_i), .regulator_en_i(reg_en),
		.supplies_ready_o(sup), .pump_ok_o(pump));

	////////////////////////////////////////////////////////////////////////////////
	task chk(input logic [31:0] got, input logic [31:0] exp);
		checks_done++;
		if (got !== exp) begin
			err_total++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk

	task conclude;
		$display("checks %0d mismatches %0d", checks_done, err_total);
		if (err_total == 0 && checks_done > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask : conclude

	task wb(input logic we, input logic [7:0] adr, input logic [31:0] dat, input logic [3:0] sel);
		int k;
		k = 0;
		@(posedge clk_i);
		wb_cyc_i <= 1;
		wb_stb_i <= 1;
		wb_we_i <= we;
		wb_adr_i <= adr;
		wb_dat_i <= dat;
		wb_sel_i <= sel;
		do begin
			@(posedge clk_i);
			k++;
		end while (wb_ack_o !== 1'b1 && k < 50);
		if (k >= 50) begin
			err_total++;
		end
		rd = wb_dat_o;
		wb_cyc_i <= 0;
		wb_stb_i <= 0;
		wb_we_i <= 0;
	endtask : wb

	task settle;
		repeat (10) @(posedge clk_i);
	endtask : settle

	// Cycles from one high-side release to the next when the limit is hit right after a release.
	task chop_gap(output int gap);
		gap = 0;
		while (gates.hs_a !== 1'b1 && gap < 200) begin
			@(posedge clk_i);
			gap++;
		end
		gap = 0;
		lim <= 1;
		repeat (3) begin
			@(posedge clk_i);
			gap++;
		end
		lim <= 0;
		while (gates.hs_a !== 1'b0 && gap < 200) begin
			@(posedge clk_i);
			gap++;
		end
		while (gates.hs_a !== 1'b1 && gap < 200) begin
			@(posedge clk_i);
			gap++;
		end
	endtask : chop_gap

	function automatic hbs_pkg::hbs_gates_t exp_gates(input logic da, input logic db, input logic half);
		return '{hs_a: da, ls_a: ~da, hs_b: db & ~half, ls_b: ~db & ~half};
	endfunction : exp_gates

	////////////////////////////////////////////////////////////////////////////////
	always @(posedge clk_i) begin
		cycles++;
		if (cycles > 20000) begin
			err_total++;
			conclude();
		end
	end

	initial begin
		void'($urandom(32'h32f8));
		repeat (12) @(posedge clk_i);
		rst_i <= 0;
		settle();
		chk({gates, slew, fs_oe, reg_en}, {4'h0, 3'h3, 2'h0});
		wb(0, hbs_pkg::REG_CTRL, 0, 4'hf);
		chk(rd, 32'h30);
		wb(0, 8'h0c, 0, 4'hf);
		chk(rd, 32'h0);
		wb(1, hbs_pkg::REG_CTRL, 32'h34, 4'hf);
		wb(1, hbs_pkg::REG_CTRL, 32'h00, 4'he);
		wb(0, hbs_pkg::REG_CTRL, 0, 4'hf);
		chk(rd, 32'h34);
		$display("test reset done");
		// Wake without a good rail is ignored.
		@(posedge clk_i) en <= 1;
		settle();
		chk(reg_en, 0);
		@(posedge clk_i) en <= 0;
		rail <= 1;
		settle();
		@(posedge clk_i) en <= 1;
		n = 0;
		while (fs_oe !== 1'b1 && n < 500) begin
			@(posedge clk_i);
			n++;
		end
		chk(sup, 1);
		chk(n < 200, 1);
		n = 0;
		while (fs_oe === 1'b1 && n < 500) begin
			@(posedge clk_i);
			n++;
		end
		chk(n >= 21, 1);
		settle();
		wb(0, hbs_pkg::REG_STATUS, 0, 4'hf);
		chk(rd[10:8], 3'h2);
		$display("test power-up done");
		for (int i = 0; i < 8; i++) begin
			a = $urandom;
			b = $urandom;
			h = (i == 5);
			@(posedge clk_i);
			dir_a <= $urandom;
			dir_b <= $urandom;
			wb(1, hbs_pkg::REG_CTRL, {i[2:0], h, 1'b1, b, a}, 4'h1);
			settle();
			chk(gates, exp_gates(a | dir_a, b | dir_b, h));
			chk({oe_a, oe_b, slew}, {1'b1, ~h, i[2:0]});
		end
		$display("test direction done");
		@(posedge clk_i) oc <= 1;
		settle();
		chk({gates, fs_oe, fs_n}, 6'h02);
		@(posedge clk_i) oc <= 0;
		settle();
		wb(0, hbs_pkg::REG_STATUS, 0, 4'hf);
		chk({rd[10:8], rd[0]}, 4'hd);
		wb(1, hbs_pkg::REG_STATUS, 32'h1f, 4'h1);
		settle();
		wb(0, hbs_pkg::REG_STATUS, 0, 4'hf);
		chk({rd[10:8], rd[0], fs_oe}, 5'h08);
		$display("test fault done");
		wb(1, hbs_pkg::REG_CTRL, 32'h35, 4'h1);
		chop_gap(g);
		chop_gap(g);
		chk(g, CHOP);
		@(posedge clk_i) ts <= 1;
		settle();
		chop_gap(g);
		chop_gap(g);
		chk(g, 2 * CHOP);
		@(posedge clk_i) ts <= 0;
		settle();
		$display("test chop done");
		@(posedge clk_i) ot <= 1;
		settle();
		chk({oe_a, oe_b, fs_oe, gates}, 7'h10);
		@(posedge clk_i) ot <= 0;
		dis <= 1;
		settle();
		@(posedge clk_i) dis <= 0;
		settle();
		wb(0, hbs_pkg::REG_STATUS, 0, 4'hf);
		chk({rd[10:8], rd[1], oe_a}, 5'h09);
		@(posedge clk_i) tw <= 1;
		settle();
		wb(0, hbs_pkg::REG_STATUS, 0, 4'hf);
		chk({rd[10:8], rd[3]}, 4'h5);
		@(posedge clk_i) tw <= 0;
		settle();
		wb(1, hbs_pkg::REG_STATUS, 32'h08, 4'h1);
		wb(0, hbs_pkg::REG_STATUS, 0, 4'hf);
		chk(rd[3], 0);
		$display("test protection done");
		@(posedge clk_i) dis <= 1;
		en <= 0;
		n = 0;
		while (reg_en === 1'b1 && n < 500) begin
			@(posedge clk_i);
			n++;
			if (n == 20) begin
				chk({oe_a, oe_b, fs_oe}, 3'h1);
			end
		end
		chk(n >= 160 && n <= 230, 1);
		settle();
		chk(fs_oe, 1);
		@(posedge clk_i) dis <= 0;
		settle();
		wb(0, hbs_pkg::REG_STATUS, 0, 4'hf);
		chk({rd[10:8], fs_oe, reg_en}, 5'h00);
		$display("test power-down done");
		conclude();
	end
endmodule : tb_hbs_sequencer
